// ---- logic/cmbio_params.svh ----
// Constants for the processor memory and serial bit I/O bus block
`ifndef CMBIO_PARAMS_SVH
`define CMBIO_PARAMS_SVH
`define CMBIO_ADDR_W      15
`define CMBIO_DATA_W      16
`define CMBIO_XOP_W       3
`define CMBIO_CNT_W       5
`define CMBIO_BITS_MAX    5'h10
`define CMBIO_CNT_ZERO    5'h00
`define CMBIO_CNT_ONE     5'h01
`define CMBIO_IO_ADDR_W   12
`define CMBIO_MAP_BIT_RST 1'b0
`define CMBIO_DWELL_ZERO  3'h0
`define CMBIO_DWELL_ONE   3'h1
`define CMBIO_DWELL_LAST  3'h5
`endif

// ---- logic/cmbio_pkg.sv ----
// Types for the processor memory and serial bit I/O bus block
package cmbio_pkg;
    // Bus sequencer states, one-hot
    typedef enum logic [8:0] {
        CMBIO_IDLE   = 9'h001,
        CMBIO_RD     = 9'h002,
        CMBIO_WR_SET = 9'h004,
        CMBIO_WR_STB = 9'h008,
        CMBIO_WR_END = 9'h010,
        CMBIO_IO_OUT = 9'h020,
        CMBIO_IO_IN  = 9'h040,
        CMBIO_XOP    = 9'h080,
        CMBIO_HOLD   = 9'h100
    } cmbio_state_e;
    // Request kinds from the core side
    typedef enum logic [2:0] {
        CMBIO_OP_RD  = 3'h0,
        CMBIO_OP_WR  = 3'h1,
        CMBIO_OP_OUT = 3'h2,
        CMBIO_OP_IN  = 3'h3,
        CMBIO_OP_XOP = 3'h4
    } cmbio_op_e;
endpackage : cmbio_pkg

// ---- logic/cmbio_sync_if.sv ----
// Carrier between the top module and the pin synchroniser
`timescale 1ns/1ns
`default_nettype none
interface cmbio_sync_if;
    logic raw_ready;  // Ready pin as received
    logic raw_hold_n; // Hold request pin as received
    logic raw_sin;    // Serial input pin as received
    logic ready;      // Filtered ready
    logic hold_n;     // Filtered hold request
    logic sin;        // Filtered serial input
    modport top  (output raw_ready, output raw_hold_n, output raw_sin, input ready, input hold_n, input sin);
    modport sync (input raw_ready, input raw_hold_n, input raw_sin, output ready, output hold_n, output sin);
endinterface : cmbio_sync_if
`default_nettype wire

// ---- logic/cmbio_pin_sync.sv ----
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
`default_nettype none
module cmbio_pin_sync (
    input wire logic   clk,
    input wire logic   rst,
    cmbio_sync_if.sync s
);
    localparam int N = 3;
    logic [N-1:0] raw_w; // Raw pin vector
    logic [N-1:0] s1_r;  // First stage, read only by second
    logic [N-1:0] s2_r;  // Second stage
    logic [N-1:0] s3_r;  // Third stage
    logic [N-1:0] out_r; // Accepted level
    assign raw_w = {s.raw_sin, s.raw_hold_n, s.raw_ready};
    // Per-bit chain; accept a change only when stages two and three agree
    genvar i;
    for (i = 0; i < N; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (rst) begin
                s1_r[i]  <= 1'b1;
                s2_r[i]  <= 1'b1;
                s3_r[i]  <= 1'b1;
                out_r[i] <= 1'b1;
            end else begin
                s1_r[i] <= raw_w[i];
                s2_r[i] <= s1_r[i];
                s3_r[i] <= s2_r[i];
                if (s2_r[i] == s3_r[i]) begin
                    out_r[i] <= s3_r[i];
                end
            end
        end
    end
    assign s.ready  = out_r[0];
    assign s.hold_n = out_r[1];
    assign s.sin    = out_r[2];
endmodule : cmbio_pin_sync
`default_nettype wire

// ---- logic/cmbio_bus.sv ----
// Memory and serial bit I/O bus sequencer of the processor
`timescale 1ns/1ns
`default_nettype none
`include "cmbio_params.svh"
module cmbio_bus
    import cmbio_pkg::*;
#(
    parameter int AW = `CMBIO_ADDR_W,
    parameter int DW = `CMBIO_DATA_W
) (
    input  wire logic          clk,            // Single-phase clock
    input  wire logic          rst,            // Synchronous reset
    // Core side
    input  wire logic          req_valid,      // Bus request
    input  wire logic [2:0]    req_op,         // Request kind
    input  wire logic [AW-1:0] req_addr,       // Word or bit address
    input  wire logic [DW-1:0] req_wdata,      // Write or serial data
    input  wire logic [4:0]    req_count,      // Serial bit count, 1..16
    input  wire logic          req_trap,       // Trap vector addressing
    input  wire logic          map_bit_we,     // Status map bit update
    input  wire logic          map_bit_val,    // New status map bit
    output var  logic          req_done,       // Request finished pulse
    output var  logic [DW-1:0] rsp_data,       // Read or serial input data
    output var  logic          status_map_bit, // Current status map bit
    // Pins
    output var  logic [AW-1:0] address_lines_o,
    output var  logic [AW-1:0] address_lines_oe_n,
    input  wire logic [DW-1:0] data_lines_i,
    output var  logic [DW-1:0] data_lines_o,
    output var  logic [DW-1:0] data_lines_oe_n,
    output var  logic          map_select_o,
    output var  logic          map_select_oe_n,
    output var  logic          memory_cycle_enable_n_o,
    output var  logic          memory_cycle_enable_n_oe_n,
    output var  logic          read_direction_o,
    output var  logic          read_direction_oe_n,
    output var  logic          write_strobe_n_o,
    output var  logic          write_strobe_n_oe_n,
    output var  logic          cycle_end_n_o,
    output var  logic          cycle_end_n_oe_n,
    output var  logic          serial_io_strobe,
    output var  logic          serial_io_out,
    input  wire logic          serial_io_in,
    input  wire logic          ready,
    output var  logic          wait_o,
    input  wire logic          hold_n,
    output var  logic          hold_grant
);
    cmbio_sync_if sy ();                  // Synchronised pin inputs
    cmbio_state_e state_r, state_nxt;     // Sequencer state
    logic [AW-1:0] addr_r;                // Address driven
    logic [DW-1:0] dout_r;                // Data driven
    logic [DW-1:0] shift_r;               // Serial shift / collect
    logic [4:0]    cnt_r;                 // Serial bits left
    logic [4:0]    idx_r;                 // Serial bit index
    logic [2:0]    dwell_r;               // Cycles spent on one input bit
    logic [2:0]    op_r;                  // Latched request kind
    logic          map_r;                 // Status map bit
    logic          trap_r;                // Trap addressing active
    logic          mem_en_r, rdir_r, wstb_r, drv_r, strb_r, sout_r, cend_r, wait_r, grant_r, done_r;
    logic [DW-1:0] rsp_r;

    assign sy.raw_ready  = ready;
    assign sy.raw_hold_n = hold_n;
    assign sy.raw_sin    = serial_io_in;

    // Inputs sampled on the rising edge through the filter
    cmbio_pin_sync u_sync (
        .clk (clk),
        .rst (rst),
        .s   (sy)
    );

    // Decode of conditions
    wire stall_w   = ~sy.ready;
    wire hold_w    = ~sy.hold_n;
    wire last_w    = (cnt_r == `CMBIO_CNT_ONE);
    // Refused in the done cycle, so a request still held then is not taken twice
    wire start_w   = req_valid & ~hold_w & ~done_r;
    wire is_mem_w  = (state_r == CMBIO_RD) | (state_r == CMBIO_WR_SET) |
                     (state_r == CMBIO_WR_STB) | (state_r == CMBIO_WR_END);
    wire [4:0] cnt_ld_w = (req_count == `CMBIO_CNT_ZERO) ? `CMBIO_BITS_MAX : req_count;
    wire [AW-1:0] bit_addr_w = addr_r + {{(AW-5){1'b0}}, idx_r};
    // Serial out: one bit every other cycle, its address held until the strobe drops
    wire out_step_w = (state_r == CMBIO_IO_OUT) & ~stall_w & ~strb_r;
    wire out_next_w = (state_r == CMBIO_IO_OUT) & strb_r;
    // Serial in: the input filter lags, so each bit address dwells before sampling
    wire in_step_w  = (state_r == CMBIO_IO_IN) & ~stall_w & (dwell_r == `CMBIO_DWELL_LAST);

    // Next-state choice; stalls freeze every state but idle, hold and write end
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CMBIO_IDLE: begin
                if (hold_w) begin
                    state_nxt = CMBIO_HOLD;
                end else if (start_w) begin
                    case (req_op)
                        CMBIO_OP_RD:  state_nxt = CMBIO_RD;
                        CMBIO_OP_WR:  state_nxt = CMBIO_WR_SET;
                        CMBIO_OP_OUT: state_nxt = CMBIO_IO_OUT;
                        CMBIO_OP_IN:  state_nxt = CMBIO_IO_IN;
                        CMBIO_OP_XOP: state_nxt = CMBIO_XOP;
                        default:      state_nxt = CMBIO_IDLE;
                    endcase
                end
            end
            CMBIO_RD:     if (!stall_w) state_nxt = CMBIO_IDLE;
            CMBIO_WR_SET: if (!stall_w) state_nxt = CMBIO_WR_STB;
            CMBIO_WR_STB: if (!stall_w) state_nxt = CMBIO_WR_END;
            CMBIO_WR_END: state_nxt = CMBIO_IDLE;
            CMBIO_IO_OUT: if (out_step_w && last_w) state_nxt = CMBIO_IDLE;
            CMBIO_IO_IN:  if (in_step_w && last_w) state_nxt = CMBIO_IDLE;
            CMBIO_XOP:    if (!stall_w) state_nxt = CMBIO_IDLE;
            CMBIO_HOLD:   if (!hold_w) state_nxt = CMBIO_IDLE;
            default:      state_nxt = CMBIO_IDLE;
        endcase
    end

    // Sequencer register
    always_ff @(posedge clk) begin
        if (rst) state_r <= CMBIO_IDLE;
        else     state_r <= state_nxt;
    end

    // Status map bit; instructions that touch it update it
    always_ff @(posedge clk) begin
        if (rst)             map_r <= `CMBIO_MAP_BIT_RST;
        else if (map_bit_we) map_r <= map_bit_val;
    end

    // Request capture: address, data, kind, trap flag
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_r <= '0;
            dout_r <= '0;
            op_r   <= 3'h0;
            trap_r <= 1'b0;
        end else if (state_r == CMBIO_IDLE && start_w) begin
            addr_r <= req_addr;
            dout_r <= req_wdata;
            op_r   <= req_op;
            trap_r <= req_trap;
        end else if (state_nxt == CMBIO_IDLE) begin
            trap_r <= 1'b0;
        end
    end

    // Serial shifting: out LSB first, inputs collected by index
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_r <= '0;
            cnt_r   <= `CMBIO_CNT_ZERO;
            idx_r   <= `CMBIO_CNT_ZERO;
        end else if (state_r == CMBIO_IDLE && start_w) begin
            shift_r <= (req_op == CMBIO_OP_IN) ? '0 : req_wdata;
            cnt_r   <= cnt_ld_w;
            idx_r   <= `CMBIO_CNT_ZERO;
        end else if (out_step_w) begin
            shift_r <= shift_r >> 1;
            cnt_r   <= cnt_r - `CMBIO_CNT_ONE;
        end else if (out_next_w) begin
            // Bit address moves only once the strobe has dropped
            idx_r   <= idx_r + `CMBIO_CNT_ONE;
        end else if (in_step_w) begin
            shift_r[idx_r[3:0]] <= sy.sin;
            cnt_r   <= cnt_r - `CMBIO_CNT_ONE;
            idx_r   <= idx_r + `CMBIO_CNT_ONE;
        end
    end

    // Dwell count per input bit; restarts outside serial input
    always_ff @(posedge clk) begin
        if (rst || state_r != CMBIO_IO_IN) dwell_r <= `CMBIO_DWELL_ZERO;
        else if (in_step_w)                dwell_r <= `CMBIO_DWELL_ZERO;
        else if (!stall_w)                 dwell_r <= dwell_r + `CMBIO_DWELL_ONE;
    end

    // Registered pin controls derived from next state; serial strobe and wait from current state
    wire nx_mem_w  = (state_nxt == CMBIO_RD) | (state_nxt == CMBIO_WR_SET) |
                     (state_nxt == CMBIO_WR_STB) | (state_nxt == CMBIO_WR_END);
    wire nx_rdir_w = (state_nxt == CMBIO_RD) | (state_nxt == CMBIO_IO_OUT) |
                     (state_nxt == CMBIO_IO_IN) | (state_nxt == CMBIO_XOP);
    wire nx_drv_w  = (state_nxt == CMBIO_WR_SET) | (state_nxt == CMBIO_WR_STB) |
                     (state_nxt == CMBIO_WR_END);
    wire strobe_w  = ((state_r == CMBIO_IO_OUT) | (state_r == CMBIO_XOP)) & ~stall_w & ~strb_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            mem_en_r <= 1'b0;
            rdir_r   <= 1'b0;
            drv_r    <= 1'b0;
            wstb_r   <= 1'b0;
            strb_r   <= 1'b0;
            sout_r   <= 1'b0;
            cend_r   <= 1'b0;
            wait_r   <= 1'b0;
            grant_r  <= 1'b0;
            done_r   <= 1'b0;
            rsp_r    <= '0;
        end else begin
            mem_en_r <= nx_mem_w;
            rdir_r   <= nx_rdir_w;
            drv_r    <= nx_drv_w & ~nx_rdir_w;
            // Strobe only in the middle write cycle: data and address settled first
            wstb_r   <= (state_nxt == CMBIO_WR_STB);
            strb_r   <= strobe_w;
            sout_r   <= out_step_w ? shift_r[0] : sout_r;
            cend_r   <= (state_nxt == CMBIO_IDLE) & (state_r != CMBIO_IDLE);
            wait_r   <= stall_w & is_mem_w | stall_w & (state_r == CMBIO_IO_OUT ||
                        state_r == CMBIO_IO_IN || state_r == CMBIO_XOP);
            grant_r  <= (state_nxt == CMBIO_HOLD);
            done_r   <= (state_nxt == CMBIO_IDLE) & (state_r != CMBIO_IDLE) & (state_r != CMBIO_HOLD);
            // Read data taken while the enable and direction pins stand active
            if (!memory_cycle_enable_n_oe_n && read_direction_o) rsp_r <= data_lines_i;
            else if (in_step_w && last_w) begin
                rsp_r <= shift_r;
                rsp_r[idx_r[3:0]] <= sy.sin;
            end
        end
    end

    // Address mux: memory word address or serial bit address
    wire [AW-1:0] addr_w = mem_en_r ? addr_r :
                           (op_r == CMBIO_OP_XOP) ? addr_r : bit_addr_w;

    // Output registers; hold releases everything to the pull-ups
    always_ff @(posedge clk) begin
        if (rst) begin
            address_lines_o            <= '1;
            address_lines_oe_n         <= '1;
            data_lines_o               <= '1;
            data_lines_oe_n            <= '1;
            map_select_o               <= 1'b1;
            map_select_oe_n            <= 1'b1;
            memory_cycle_enable_n_o    <= 1'b1;
            memory_cycle_enable_n_oe_n <= 1'b1;
            read_direction_o           <= 1'b0;
            read_direction_oe_n        <= 1'b1;
            write_strobe_n_o           <= 1'b1;
            write_strobe_n_oe_n        <= 1'b1;
            cycle_end_n_o              <= 1'b1;
            cycle_end_n_oe_n           <= 1'b1;
            hold_grant                 <= 1'b0;
        end else begin
            // Open collector, read direction excepted: only low levels are driven
            address_lines_o            <= '0;
            address_lines_oe_n         <= grant_r ? '1 : addr_w;
            data_lines_o               <= '0;
            data_lines_oe_n            <= (grant_r | ~drv_r) ? '1 : dout_r;
            map_select_o               <= 1'b0;
            map_select_oe_n            <= grant_r | trap_r | ~map_r;
            memory_cycle_enable_n_o    <= 1'b0;
            memory_cycle_enable_n_oe_n <= grant_r | ~mem_en_r;
            read_direction_o           <= rdir_r;
            read_direction_oe_n        <= grant_r;
            write_strobe_n_o           <= 1'b0;
            write_strobe_n_oe_n        <= grant_r | ~wstb_r;
            cycle_end_n_o              <= 1'b0;
            cycle_end_n_oe_n           <= grant_r | ~cend_r;
            // Grant shown on the same edge as the release it announces
            hold_grant                 <= grant_r;
        end
    end

    assign serial_io_strobe = strb_r;
    assign serial_io_out    = sout_r;
    assign wait_o           = wait_r;
    assign req_done         = done_r;
    assign rsp_data         = rsp_r;
    assign status_map_bit   = map_r;
endmodule : cmbio_bus
`default_nettype wire

// ---- verif/cmbio_bus_checker.sv ----
// Pin-level property checker for the memory and serial bit I/O bus
`timescale 1ns/1ns
`default_nettype none
module cmbio_bus_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        req_trap,
    input wire logic        ready,
    input wire logic        status_map_bit,
    input wire logic [14:0] address_lines_oe_n,
    input wire logic [15:0] data_lines_oe_n,
    input wire logic        map_select_oe_n,
    input wire logic        memory_cycle_enable_n_oe_n,
    input wire logic        read_direction_o,
    input wire logic        read_direction_oe_n,
    input wire logic        write_strobe_n_oe_n,
    input wire logic        serial_io_strobe,
    input wire logic        serial_io_out,
    input wire logic        wait_o,
    input wire logic        hold_grant,
    input wire logic        req_done,
    input wire logic        cycle_end_n_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Granted bus must rest released, so other masters see high lines
    hold_release_a: assert property (
        hold_grant |-> &{address_lines_oe_n, data_lines_oe_n, map_select_oe_n, memory_cycle_enable_n_oe_n,
                         read_direction_oe_n, write_strobe_n_oe_n}) else $error("bus held while granted");
    strobe_after_enable_a: assert property (
        $fell(write_strobe_n_oe_n) |-> !$past(memory_cycle_enable_n_oe_n) && !memory_cycle_enable_n_oe_n)
        else $error("write strobe before enable");
    strobe_before_end_a: assert property (
        $rose(write_strobe_n_oe_n) |-> !memory_cycle_enable_n_oe_n) else $error("enable ended with strobe");
    write_steady_a: assert property (
        !write_strobe_n_oe_n |-> $stable(data_lines_oe_n) && $stable(address_lines_oe_n))
        else $error("address or data moved under strobe");
    read_release_a: assert property (
        (read_direction_o && !read_direction_oe_n && !memory_cycle_enable_n_oe_n) |-> &data_lines_oe_n)
        else $error("data drivers on during read");
    serial_dir_a: assert property (
        serial_io_strobe |-> read_direction_o && !read_direction_oe_n && memory_cycle_enable_n_oe_n)
        else $error("serial strobe without read direction");
    serial_pulse_a: assert property (
        serial_io_strobe |=> !serial_io_strobe && $stable(serial_io_out) && $stable(address_lines_oe_n))
        else $error("serial output moved with strobe");
    map_follow_a: assert property (
        (!hold_grant && !$past(hold_grant) && !$past(hold_grant, 2) && !req_trap && !$past(req_trap)
         && !$past(req_trap, 2) && $stable(status_map_bit) && status_map_bit == $past(status_map_bit, 2))
        |-> map_select_oe_n == !status_map_bit) else $error("map select not inverse of status bit");
    trap_force_a: assert property (
        (!memory_cycle_enable_n_oe_n && req_trap && $past(req_trap)) |-> map_select_oe_n)
        else $error("map select low during trap");
    wait_clear_a: assert property (
        ready [*8] |-> !wait_o) else $error("wait while ready");
    cycle_end_a: assert property (
        req_done |=> !cycle_end_n_oe_n) else $error("cycle end missing after completion");
endmodule : cmbio_bus_checker
`default_nettype wire

// ---- verif/cmbio_far_model.sv ----
// Far-side model: two-bank memory and serial bit file
`timescale 1ns/1ns
`default_nettype none
module cmbio_far_model (
    input  wire logic        clk,
    input  wire logic [14:0] addr_w,
    input  wire logic [15:0] data_w,
    input  wire logic        map_w,
    input  wire logic        mem_en_n_w,
    input  wire logic        rd_dir_w,
    input  wire logic        we_n_w,
    input  wire logic        sio_strobe,
    input  wire logic        sio_out,
    output var  logic [15:0] mem_level,
    output var  logic        sio_in,
    output var  logic [14:0] last_addr
);
    logic [15:0] mem [32];               // Bank chosen by map select
    logic [15:0] io_bits;                // Serial bit file, 16 places
    wire  logic [4:0] idx = {map_w, addr_w[3:0]};
    // Store on write strobe; capture serial bit and address on its strobe
    always @(posedge clk) begin
        if (!mem_en_n_w && !we_n_w) begin
            mem[idx] <= data_w;
        end
        if (sio_strobe) begin
            io_bits[addr_w[3:0]] <= sio_out;
            last_addr <= addr_w;
        end
    end
    // Drive read data only while selected and device drivers off; pull-up otherwise
    assign mem_level = (!mem_en_n_w && rd_dir_w && we_n_w) ? mem[idx] : 16'hffff;
    // Unselected serial input toggles so stale values cannot pass
    assign sio_in = (mem_en_n_w && rd_dir_w) ? io_bits[addr_w[3:0]] : clk;
endmodule : cmbio_far_model
`default_nettype wire

// ---- verif/cmbio_bus_bench.sv ----
// Self-checking bench for the memory and serial bit I/O bus
`timescale 1ns/1ns
`default_nettype none
module cmbio_bus_bench;
    import cmbio_pkg::*;
    typedef struct packed {logic [2:0] op; logic [14:0] addr; logic [15:0] wd; logic [4:0] cnt; logic [15:0] exp;} cmbio_row_s;
    logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_trap = 1'b0, map_bit_we = 1'b0, map_bit_val = 1'b0;
    logic ready = 1'b1, hold_n = 1'b1;
    logic [2:0] req_op = 3'h0;
    logic [14:0] req_addr = 15'h0000, address_lines_o, address_lines_oe_n, last_addr;
    logic [15:0] req_wdata = 16'h0000, rsp_data, data_lines_o, data_lines_oe_n, mem_level, msk;
    logic [4:0] req_count = 5'h00;
    logic req_done, status_map_bit, map_select_o, map_select_oe_n, memory_cycle_enable_n_o;
    logic memory_cycle_enable_n_oe_n, read_direction_o, read_direction_oe_n, write_strobe_n_o, write_strobe_n_oe_n;
    logic cycle_end_n_o, cycle_end_n_oe_n, serial_io_strobe, serial_io_out, serial_io_in, wait_o, hold_grant;
    int comparisons = 0, n_mismatch = 0, n;
    // Open-collector wires: low only where some party pulls
    wire logic [14:0] addr_w = address_lines_oe_n | address_lines_o;
    wire logic [15:0] data_w = (data_lines_oe_n | data_lines_o) & mem_level;
    wire logic map_w = map_select_oe_n | map_select_o;
    wire logic men_w = memory_cycle_enable_n_oe_n | memory_cycle_enable_n_o;
    wire logic we_w = write_strobe_n_oe_n | write_strobe_n_o;
    wire logic rd_w = read_direction_oe_n | read_direction_o;
    // Ordinary transfers: writes, reads, both serial directions, external code
    cmbio_row_s rows [9] = '{
        '{CMBIO_OP_WR, 15'h0003, 16'ha5c3, 5'h00, 16'h0000}, '{CMBIO_OP_WR, 15'h0004, 16'h0f1e, 5'h00, 16'h0000},
        '{CMBIO_OP_RD, 15'h0003, 16'h0000, 5'h00, 16'ha5c3}, '{CMBIO_OP_RD, 15'h0004, 16'h0000, 5'h00, 16'h0f1e},
        '{CMBIO_OP_OUT, 15'h0008, 16'h0005, 5'h04, 16'h0000}, '{CMBIO_OP_IN, 15'h0008, 16'h0000, 5'h04, 16'h0005},
        '{CMBIO_OP_OUT, 15'h0000, 16'h8001, 5'h00, 16'h0000}, '{CMBIO_OP_IN, 15'h0000, 16'h0000, 5'h00, 16'h8001},
        '{CMBIO_OP_XOP, 15'h5000, 16'h0000, 5'h00, 16'h0005}};

    cmbio_bus dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_count(req_count), .req_trap(req_trap), .map_bit_we(map_bit_we),
        .map_bit_val(map_bit_val), .req_done(req_done), .rsp_data(rsp_data), .status_map_bit(status_map_bit),
        .address_lines_o(address_lines_o), .address_lines_oe_n(address_lines_oe_n), .data_lines_i(data_w),
        .data_lines_o(data_lines_o), .data_lines_oe_n(data_lines_oe_n), .map_select_o(map_select_o),
        .map_select_oe_n(map_select_oe_n), .memory_cycle_enable_n_o(memory_cycle_enable_n_o),
        .memory_cycle_enable_n_oe_n(memory_cycle_enable_n_oe_n), .read_direction_o(read_direction_o),
        .read_direction_oe_n(read_direction_oe_n), .write_strobe_n_o(write_strobe_n_o),
        .write_strobe_n_oe_n(write_strobe_n_oe_n), .cycle_end_n_o(cycle_end_n_o), .cycle_end_n_oe_n(cycle_end_n_oe_n),
        .serial_io_strobe(serial_io_strobe), .serial_io_out(serial_io_out), .serial_io_in(serial_io_in),
        .ready(ready), .wait_o(wait_o), .hold_n(hold_n), .hold_grant(hold_grant));
    cmbio_far_model far (.clk(clk), .addr_w(addr_w), .data_w(data_w), .map_w(map_w), .mem_en_n_w(men_w),
        .rd_dir_w(rd_w), .we_n_w(we_w), .sio_strobe(serial_io_strobe), .sio_out(serial_io_out),
        .mem_level(mem_level), .sio_in(serial_io_in), .last_addr(last_addr));

    always #20 clk = ~clk;
    // Compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One request held until its done pulse, bounded
    task automatic do_req(input logic [2:0] op, input logic [14:0] a, input logic [15:0] wd, input logic [4:0] c,
                          input logic trap);
        int k;
        @(posedge clk);
        {req_valid, req_op, req_addr, req_wdata, req_count, req_trap} <= {1'b1, op, a, wd, c, trap};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (req_done !== 1'b1 && k < 300);
        if (k >= 300) check("request done", 16'h0000, 16'h0001);
        {req_valid, req_trap} <= 2'b00;
        @(posedge clk);
    endtask : do_req
    // Counts, verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("grant after reset", hold_grant, 16'h0000);
        check("map after reset", {men_w, map_w, status_map_bit}, 16'h0006);
        $display("reset test done");
        foreach (rows[i]) begin
            do_req(rows[i].op, rows[i].addr, rows[i].wd, rows[i].cnt, 1'b0);
            msk = (rows[i].cnt == 5'h00) ? 16'hffff : 16'((17'h00001 << rows[i].cnt) - 17'h00001);
            if (rows[i].op == CMBIO_OP_RD) check("read data", rsp_data, rows[i].exp);
            if (rows[i].op == CMBIO_OP_IN) check("serial bits", rsp_data & msk, rows[i].exp);
            if (rows[i].op == CMBIO_OP_XOP) check("external code", {13'h0000, last_addr[14:12]}, rows[i].exp);
        end
        $display("row tests done");
        {map_bit_we, map_bit_val} <= 2'b11;
        @(posedge clk);
        map_bit_we <= 1'b0;
        repeat (3) @(posedge clk);
        check("map bit set", {status_map_bit, map_w}, 16'h0002);
        do_req(CMBIO_OP_WR, 15'h0003, 16'h1234, 5'h00, 1'b0);
        do_req(CMBIO_OP_RD, 15'h0003, 16'h0000, 5'h00, 1'b0);
        check("upper bank", rsp_data, 16'h1234);
        do_req(CMBIO_OP_RD, 15'h0003, 16'h0000, 5'h00, 1'b1);
        check("trap bank", rsp_data, 16'ha5c3);
        $display("map test done");
        ready <= 1'b0;
        repeat (6) @(posedge clk);
        fork
            do_req(CMBIO_OP_RD, 15'h0003, 16'h0000, 5'h00, 1'b0);
            begin
                for (n = 0; n < 30 && wait_o !== 1'b1; n++) @(posedge clk);
                check("wait raised", wait_o, 16'h0001);
                repeat (4) @(posedge clk);
                ready <= 1'b1;
            end
        join
        check("read after wait", rsp_data, 16'h1234);
        $display("wait test done");
        hold_n <= 1'b0;
        for (n = 0; n < 30 && hold_grant !== 1'b1; n++) @(posedge clk);
        @(posedge clk);
        check("grant", hold_grant, 16'h0001);
        check("address rest", {1'b0, addr_w}, 16'h7fff);
        check("data rest", data_w, 16'hffff);
        check("controls rest", {rd_w, we_w, men_w, map_w}, 16'h000f);
        hold_n <= 1'b1;
        for (n = 0; n < 30 && hold_grant !== 1'b0; n++) @(posedge clk);
        check("grant ended", hold_grant, 16'h0000);
        do_req(CMBIO_OP_RD, 15'h0004, 16'h0000, 5'h00, 1'b1);
        check("resume read", rsp_data, 16'h0f1e);
        $display("hold test done");
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("map bit reset", status_map_bit, 16'h0000);
        $display("second reset test done");
        results();
    end
endmodule : cmbio_bus_bench
bind cmbio_bus cmbio_bus_checker chk (.clk(clk), .rst(rst), .req_trap(req_trap), .ready(ready),
    .status_map_bit(status_map_bit), .address_lines_oe_n(address_lines_oe_n), .data_lines_oe_n(data_lines_oe_n),
    .map_select_oe_n(map_select_oe_n), .memory_cycle_enable_n_oe_n(memory_cycle_enable_n_oe_n),
    .read_direction_o(read_direction_o), .read_direction_oe_n(read_direction_oe_n),
    .write_strobe_n_oe_n(write_strobe_n_oe_n), .serial_io_strobe(serial_io_strobe),
    .serial_io_out(serial_io_out), .wait_o(wait_o), .hold_grant(hold_grant), .req_done(req_done),
    .cycle_end_n_oe_n(cycle_end_n_oe_n));
`default_nettype wire
